//--- pmlc_top.sv
`timescale 1ns/1ps
`include "pmlc_defines.svh"
// What this block does
// - Limits power up at factory defaults
// - Limit writes need disabled, low input, bias
// - Overvoltage lockout tracks fault limit minus 3%
// - Undervoltage override only restores preset default
// - Turn-on delay 0-100 ms after UV delay
// - Disabled temperature read returns -273
// - Enable and threshold changes need bias supply
// - Telemetry lost without bias when input removed
// - Strap address captured once, then held
// - Strap voltage decoded into 16 windows
// - Disabled low-side voltage read returns -3000
module pmlc_top import pmlc_pkg::*; #(
	parameter int COMMIT_CYC = `PMLC_COMMIT_CYC,
	parameter int TICK_CYC   = `PMLC_TICK_CYC,
	parameter int ADDR_CYC   = `PMLC_ADDR_REG_CYC
) (
	// Clock and reset
	input  wire logic        CLK,
	input  wire logic        RST,
	// Link command port
	input  wire logic        LINK_CLK,
	input  wire logic        LINK_REQ,
	input  wire logic        LINK_RD,
	input  wire logic [7:0]  LINK_CMD,
	input  wire pmlc_word_t  LINK_WDATA,
	output logic             LINK_BUSY,
	output logic             LINK_RVALID,
	output pmlc_word_t       LINK_RDATA,
	// Supply and power-train status pins
	input  wire logic        BIAS_PRESENT,
	input  wire logic        HI_BELOW_UVLO,
	input  wire logic        HI_PRESENT,
	input  wire logic        UV_DELAY_DONE,
	// Measurements, same clock
	input  wire pmlc_word_t  VIN_MEAS,
	input  wire pmlc_word_t  IIN_MEAS,
	input  wire pmlc_word_t  TEMP_MEAS,
	input  wire pmlc_word_t  VLO_MEAS,
	// Address strap
	input  wire logic [11:0] ADDR_STRAP_MV,
	output logic [3:0]       BUS_ADDR,
	output logic             ADDR_VALID,
	// Control and status
	output pmlc_word_t       OVLO_LEVEL,
	output logic             CONV_RUN,
	output logic             NV_BUSY,
	output logic             NV_STORE,
	output logic             WR_REFUSED,
	output logic [5:0]       LIMIT_FLAGS
);
	// ************************************************************
	// Limit table
	// ************************************************************
	localparam int SLOTS = 8;
	localparam int S_OTF = 0, S_OVF = 2, S_TON = 6, S_UV = 7;
	localparam logic [7:0] SLOT_CMD [SLOTS] = '{`PMLC_CMD_OT_FAULT, `PMLC_CMD_OT_WARN,
		`PMLC_CMD_OV_FAULT, `PMLC_CMD_OV_WARN, `PMLC_CMD_OC_FAULT, `PMLC_CMD_OC_WARN,
		`PMLC_CMD_TON, `PMLC_CMD_UV_OVR};
	localparam pmlc_word_t SLOT_DEF [SLOTS] = '{`PMLC_DEF_OT, `PMLC_DEF_OT, `PMLC_DEF_OV,
		`PMLC_DEF_OV, `PMLC_DEF_OC, `PMLC_DEF_OC, `PMLC_DEF_TON, `PMLC_DEF_UV};
	localparam int CW = $clog2(COMMIT_CYC + 1);
	localparam int TW = $clog2(TICK_CYC + 1);

	logic       core_req, core_rd, en_ff, rsp_ff;
	logic [7:0] core_cmd;
	pmlc_word_t core_wdata, rdat_ff;
	logic [3:0] s1_ff, s2_ff;
	logic       bias, below, hi_on, uvd;
	logic       hit_any, wr_req, wr_ok;
	logic [2:0] hit_slot;
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);
	// ************************************************************
	// Link crossing and address strap
	// ************************************************************
	pmlc_link_cdc u_cdc (
		.clk         (CLK),
		.rst         (RST),
		.core_req    (core_req),
		.core_rd     (core_rd),
		.core_cmd    (core_cmd),
		.core_wdata  (core_wdata),
		.core_rsp    (rsp_ff),
		.core_rdata  (rdat_ff),
		.link_clk    (LINK_CLK),
		.link_req    (LINK_REQ),
		.link_rd     (LINK_RD),
		.link_cmd    (LINK_CMD),
		.link_wdata  (LINK_WDATA),
		.link_busy   (LINK_BUSY),
		.link_rvalid (LINK_RVALID),
		.link_rdata  (LINK_RDATA)
	);
	pmlc_addr_strap #(.REG_CYC(ADDR_CYC)) u_strap (
		.clk        (CLK),
		.rst        (RST),
		.strap_mv   (ADDR_STRAP_MV),
		.addr       (BUS_ADDR),
		.addr_valid (ADDR_VALID)
	);
	// ************************************************************
	// Pin synchronisers
	// ************************************************************
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			s1_ff <= 4'h0;
			s2_ff <= 4'h0;
		end else begin
			s1_ff <= {UV_DELAY_DONE, HI_PRESENT, HI_BELOW_UVLO, BIAS_PRESENT};
			s2_ff <= s1_ff;
		end
	end
	assign {uvd, hi_on, below, bias} = s2_ff;
	always_comb begin
		hit_any  = 1'b0;
		hit_slot = 3'h0;
		for (int i = 0; i < SLOTS; i++) begin
			if (core_cmd == SLOT_CMD[i]) begin
				hit_any  = 1'b1;
				hit_slot = 3'(i);
			end
		end
	end
	assign wr_req = core_req && !core_rd;
	assign wr_ok  = !en_ff && below && bias;
	// ************************************************************
	// Configuration and commit
	// ************************************************************
	pmlc_word_t    lim_ff [SLOTS];
	pmlc_word_t    nxt_lim [SLOTS];
	logic          nxt_en, ref_ff, nxt_ref, busy_ff, store_ff;
	logic [CW-1:0] cnt_ff, nxt_cnt;
	pmlc_word_t    ovlo_ff, nxt_ovlo;

	always_comb begin
		nxt_lim = lim_ff;
		nxt_en  = en_ff;
		nxt_ref = 1'b0;
		nxt_cnt = (cnt_ff != '0) ? cnt_ff - CW'(1) : cnt_ff;
		if (wr_req && core_cmd == `PMLC_CMD_OPERATION) begin
			if (bias) begin
				nxt_en = core_wdata[`PMLC_OPER_ON_BIT];
			end else begin
				nxt_ref = 1'b1;
			end
		end else if (wr_req && hit_any) begin
			if (wr_ok) begin
				if (hit_slot == 3'(S_UV)) begin
					nxt_lim[hit_slot] = SLOT_DEF[S_UV];
				end else if (hit_slot == 3'(S_TON) && core_wdata > `PMLC_TON_MAX_MS) begin
					nxt_lim[hit_slot] = `PMLC_TON_MAX_MS;
				end else begin
					nxt_lim[hit_slot] = core_wdata;
				end
				// Restart on every accepted limit write so the last value is the one stored
				nxt_cnt = CW'(COMMIT_CYC);
			end else begin
				nxt_ref = 1'b1;
			end
		end
		nxt_ovlo = 16'((32'(lim_ff[S_OVF]) * `PMLC_OVLO_PCT) / `PMLC_PCT_FULL);
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			lim_ff   <= SLOT_DEF;
			en_ff    <= 1'b0;
			ref_ff   <= 1'b0;
			cnt_ff   <= '0;
			busy_ff  <= 1'b0;
			store_ff <= 1'b0;
			ovlo_ff  <= 16'h0000;
		end else begin
			lim_ff   <= nxt_lim;
			en_ff    <= nxt_en;
			ref_ff   <= nxt_ref;
			cnt_ff   <= nxt_cnt;
			busy_ff  <= (nxt_cnt != '0);
			store_ff <= (cnt_ff == CW'(1));
			ovlo_ff  <= nxt_ovlo;
		end
	end

	// ************************************************************
	// Start sequence
	// ************************************************************
	pmlc_start_t   st_ff, nxt_st;
	logic [TW-1:0] tick_ff, nxt_tick;
	pmlc_word_t    ms_ff, nxt_ms;
	logic          run_ff;

	always_comb begin
		nxt_st   = st_ff;
		nxt_tick = tick_ff;
		nxt_ms   = ms_ff;
		case (st_ff)
			ST_OFF: begin
				if (en_ff && !below) nxt_st = ST_UV_WAIT;
			end
			ST_UV_WAIT: begin
				if (uvd) begin
					nxt_st   = ST_TON_WAIT;
					nxt_tick = '0;
					nxt_ms   = 16'h0000;
				end
			end
			ST_TON_WAIT: begin
				if (ms_ff >= lim_ff[S_TON]) begin
					nxt_st = ST_RUN;
				end else if (tick_ff == TW'(TICK_CYC - 1)) begin
					nxt_tick = '0;
					nxt_ms   = ms_ff + 16'h0001;
				end else begin
					nxt_tick = tick_ff + TW'(1);
				end
			end
			ST_RUN: begin
				nxt_st = ST_RUN;
			end
			default: begin
				nxt_st = ST_OFF;
			end
		endcase
		if (!en_ff || below) nxt_st = ST_OFF;
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			st_ff   <= ST_OFF;
			tick_ff <= '0;
			ms_ff   <= 16'h0000;
			run_ff  <= 1'b0;
		end else begin
			st_ff   <= nxt_st;
			tick_ff <= nxt_tick;
			ms_ff   <= nxt_ms;
			run_ff  <= (nxt_st == ST_RUN);
		end
	end

	// ************************************************************
	// Telemetry, read answers and limit compare
	// ************************************************************
	pmlc_word_t tvlo_ff, nxt_tvlo, ttemp_ff, nxt_ttemp, nxt_rdat;
	logic [5:0] flag_ff, nxt_flag;
	pmlc_word_t cmp_meas [6];

	assign cmp_meas = '{VIN_MEAS, VIN_MEAS, IIN_MEAS, IIN_MEAS, TEMP_MEAS, TEMP_MEAS};

	always_comb begin
		nxt_tvlo  = VLO_MEAS;
		nxt_ttemp = TEMP_MEAS;
		// Without bias the held values vanish once the input goes away
		if (!bias && !hi_on) begin
			nxt_tvlo  = 16'h0000;
			nxt_ttemp = 16'h0000;
		end
		nxt_rdat = rdat_ff;
		if (core_req && core_rd) begin
			case (core_cmd)
				`PMLC_CMD_OPERATION: nxt_rdat = {8'h00, en_ff, 7'h00};
				`PMLC_CMD_READ_VLO:  nxt_rdat = en_ff ? tvlo_ff : `PMLC_DEF_VLO;
				`PMLC_CMD_READ_TEMP: nxt_rdat = en_ff ? ttemp_ff : `PMLC_DEF_TEMP;
				default:             nxt_rdat = hit_any ? lim_ff[hit_slot] : 16'h0000;
			endcase
		end
	end

	// Flag order: OV fault, OV warn, OC fault, OC warn, OT fault, OT warn
	for (genvar g = 0; g < 6; g++) begin : g_cmp
		localparam int SL = (g + 2) % 6;
		assign nxt_flag[g] = (cmp_meas[g] > lim_ff[SL]);
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			tvlo_ff  <= 16'h0000;
			ttemp_ff <= 16'h0000;
			rdat_ff  <= 16'h0000;
			rsp_ff   <= 1'b0;
			flag_ff  <= 6'h00;
		end else begin
			tvlo_ff  <= nxt_tvlo;
			ttemp_ff <= nxt_ttemp;
			rdat_ff  <= nxt_rdat;
			rsp_ff   <= core_req;
			flag_ff  <= nxt_flag;
		end
	end

	assign OVLO_LEVEL  = ovlo_ff;
	assign CONV_RUN    = run_ff;
	assign NV_BUSY     = busy_ff;
	assign NV_STORE    = store_ff;
	assign WR_REFUSED  = ref_ff;
	assign LIMIT_FLAGS = flag_ff;

	// ************************************************************
	// Checks
	// ************************************************************
	pmlc_word_t sel_lim;
	assign sel_lim = lim_ff[hit_slot];
	sequence s_ov_write;
		wr_req && wr_ok && core_cmd == `PMLC_CMD_OV_FAULT;
	endsequence
	a_boot_defaults: assert property ($fell(RST) |->
		(lim_ff[S_OVF] == `PMLC_DEF_OV && lim_ff[S_OTF] == `PMLC_DEF_OT))
		else $error("limits not at factory values after reset");
	a_refused_hold: assert property ((wr_req && hit_any && !wr_ok) |=>
		(lim_ff[$past(hit_slot)] == $past(sel_lim) && WR_REFUSED))
		else $error("refused write changed a limit");
	a_uv_preset: assert property ((wr_req && wr_ok && core_cmd == `PMLC_CMD_UV_OVR) |=>
		(lim_ff[S_UV] == `PMLC_DEF_UV))
		else $error("undervoltage override took a free value");
	a_ovlo_track: assert property (s_ov_write |-> ##2
		(OVLO_LEVEL == 16'((32'($past(core_wdata, 2)) * 97) / 100)))
		else $error("lockout level not 97 percent of fault limit");
	a_temp_default: assert property ((core_req && core_rd &&
		core_cmd == `PMLC_CMD_READ_TEMP && !en_ff) |=> (rdat_ff == 16'hFEEF && rsp_ff))
		else $error("disabled temperature read not default");
	a_vlo_default: assert property ((core_req && core_rd &&
		core_cmd == `PMLC_CMD_READ_VLO && !en_ff) |=> (rdat_ff == 16'hF448))
		else $error("disabled low-side voltage read not default");
	a_enable_bias: assert property ((wr_req && core_cmd == `PMLC_CMD_OPERATION && !bias)
		|=> (en_ff == $past(en_ff)))
		else $error("enable changed without bias");
	a_start_order: assert property ($rose(run_ff) |->
		($past(st_ff) == ST_TON_WAIT && ms_ff >= lim_ff[S_TON] && lim_ff[S_TON] <= 16'h0064))
		else $error("converter started before turn-on delay");
	a_commit_busy: assert property ((wr_req && hit_any && wr_ok) |=> NV_BUSY [*2])
		else $error("commit not started after limit write");
endmodule : pmlc_top

//--- pmlc_defines.svh
`ifndef PMLC_DEFINES_SVH
`define PMLC_DEFINES_SVH

// ************************************************************
// Command codes
// ************************************************************
`define PMLC_CMD_OPERATION 8'h01
`define PMLC_CMD_OT_FAULT  8'h4F
`define PMLC_CMD_OT_WARN   8'h51
`define PMLC_CMD_OV_FAULT  8'h55
`define PMLC_CMD_OV_WARN   8'h57
`define PMLC_CMD_OC_FAULT  8'h5B
`define PMLC_CMD_OC_WARN   8'h5D
`define PMLC_CMD_TON       8'h60
`define PMLC_CMD_UV_OVR    8'hD7
`define PMLC_CMD_READ_VLO  8'h8B
`define PMLC_CMD_READ_TEMP 8'h8D

// ************************************************************
// Field positions and reset values
// ************************************************************
`define PMLC_OPER_ON_BIT   7
`define PMLC_DEF_OT        16'h007D
`define PMLC_DEF_OV        16'h1D4C
`define PMLC_DEF_OC        16'h1130
`define PMLC_DEF_TON       16'h0000
`define PMLC_DEF_UV        16'h0FA0
`define PMLC_DEF_TEMP      16'hFEEF
`define PMLC_DEF_VLO       16'hF448
`define PMLC_TON_MAX_MS    16'h0064
`define PMLC_OVLO_PCT      97
`define PMLC_PCT_FULL      100
`define PMLC_ADDR_STEP_CMV 20625
`define PMLC_CMV_PER_MV    100
`define PMLC_ADDR_MAX      4'hF

// ************************************************************
// Timing
// ************************************************************
`define PMLC_CLK_PERIOD_NS    50
`define PMLC_COMMIT_TIME_US   3000
`define PMLC_TICK_TIME_US     1000
`define PMLC_ADDR_REG_TIME_US 1000
`define PMLC_COMMIT_CYC   (`PMLC_COMMIT_TIME_US * 1000 / `PMLC_CLK_PERIOD_NS)
`define PMLC_TICK_CYC     (`PMLC_TICK_TIME_US * 1000 / `PMLC_CLK_PERIOD_NS)
`define PMLC_ADDR_REG_CYC (`PMLC_ADDR_REG_TIME_US * 1000 / `PMLC_CLK_PERIOD_NS)

`endif

//--- pmlc_pkg.sv
package pmlc_pkg;
	typedef logic [15:0] pmlc_word_t;
	typedef enum logic [1:0] {ST_OFF, ST_UV_WAIT, ST_TON_WAIT, ST_RUN} pmlc_start_t;
endpackage : pmlc_pkg

//--- pmlc_link_cdc.sv
`timescale 1ns/1ps
module pmlc_link_cdc import pmlc_pkg::*; (
	// Core domain
	input  wire logic       clk,
	input  wire logic       rst,
	output logic            core_req,
	output logic            core_rd,
	output logic [7:0]      core_cmd,
	output pmlc_word_t      core_wdata,
	input  wire logic       core_rsp,
	input  wire pmlc_word_t core_rdata,
	// Link domain
	input  wire logic       link_clk,
	input  wire logic       link_req,
	input  wire logic       link_rd,
	input  wire logic [7:0] link_cmd,
	input  wire pmlc_word_t link_wdata,
	output logic            link_busy,
	output logic            link_rvalid,
	output pmlc_word_t      link_rdata
);
	// ************************************************************
	// Link side: hold request, toggle across, wait for ack toggle
	// ************************************************************
	logic       busy_ff, nxt_busy, tgl_ff, nxt_tgl, rd_ff, nxt_rd, rv_ff, nxt_rv;
	logic [7:0] cmd_ff, nxt_cmd;
	pmlc_word_t wd_ff, nxt_wd, rdat_ff, nxt_rdat;
	logic       ack1_ff, ack2_ff, ack_seen_ff;
	logic       ack_tgl_ff, nxt_ack_tgl, req1_ff, req2_ff, req_seen_ff;

	always_comb begin
		nxt_busy = busy_ff;
		nxt_tgl  = tgl_ff;
		nxt_rd   = rd_ff;
		nxt_cmd  = cmd_ff;
		nxt_wd   = wd_ff;
		nxt_rv   = 1'b0;
		nxt_rdat = rdat_ff;
		if (ack2_ff != ack_seen_ff) begin
			// Held core data is stable until the next request is taken
			nxt_busy = 1'b0;
			nxt_rv   = rd_ff;
			nxt_rdat = core_rdata;
		end else if (link_req && !busy_ff) begin
			nxt_busy = 1'b1;
			nxt_tgl  = ~tgl_ff;
			nxt_rd   = link_rd;
			nxt_cmd  = link_cmd;
			nxt_wd   = link_wdata;
		end
	end

	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			busy_ff     <= 1'b0;
			tgl_ff      <= 1'b0;
			rd_ff       <= 1'b0;
			cmd_ff      <= 8'h00;
			wd_ff       <= 16'h0000;
			rv_ff       <= 1'b0;
			rdat_ff     <= 16'h0000;
			ack1_ff     <= 1'b0;
			ack2_ff     <= 1'b0;
			ack_seen_ff <= 1'b0;
		end else begin
			busy_ff     <= nxt_busy;
			tgl_ff      <= nxt_tgl;
			rd_ff       <= nxt_rd;
			cmd_ff      <= nxt_cmd;
			wd_ff       <= nxt_wd;
			rv_ff       <= nxt_rv;
			rdat_ff     <= nxt_rdat;
			ack1_ff     <= ack_tgl_ff;
			ack2_ff     <= ack1_ff;
			ack_seen_ff <= ack2_ff;
		end
	end

	assign link_busy   = busy_ff;
	assign link_rvalid = rv_ff;
	assign link_rdata  = rdat_ff;

	// ************************************************************
	// Core side
	// ************************************************************
	assign nxt_ack_tgl = core_rsp ? ~ack_tgl_ff : ack_tgl_ff;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			req1_ff     <= 1'b0;
			req2_ff     <= 1'b0;
			req_seen_ff <= 1'b0;
			ack_tgl_ff  <= 1'b0;
		end else begin
			req1_ff     <= tgl_ff;
			req2_ff     <= req1_ff;
			req_seen_ff <= req2_ff;
			ack_tgl_ff  <= nxt_ack_tgl;
		end
	end

	assign core_req   = req2_ff ^ req_seen_ff;
	assign core_rd    = rd_ff;
	assign core_cmd   = cmd_ff;
	assign core_wdata = wd_ff;
endmodule : pmlc_link_cdc

//--- pmlc_addr_strap.sv
`timescale 1ns/1ps
`include "pmlc_defines.svh"
module pmlc_addr_strap import pmlc_pkg::*; #(
	parameter int REG_CYC = `PMLC_ADDR_REG_CYC
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [11:0] strap_mv,
	output logic [3:0]       addr,
	output logic             addr_valid
);
	localparam int CW = $clog2(REG_CYC + 1);
	logic [11:0]   s1_ff, s2_ff;
	logic [CW-1:0] cnt_ff, nxt_cnt;
	logic [3:0]    addr_ff, nxt_addr;
	logic          val_ff, nxt_val;
	logic [31:0]   win;

	assign win = (32'(s2_ff) * `PMLC_CMV_PER_MV) / `PMLC_ADDR_STEP_CMV;

	always_comb begin
		nxt_cnt  = cnt_ff;
		nxt_addr = addr_ff;
		nxt_val  = val_ff;
		// Sampled once; strap moves afterwards are ignored until power reset
		if (!val_ff) begin
			if (cnt_ff == CW'(REG_CYC - 1)) begin
				nxt_val  = 1'b1;
				nxt_addr = (win > 32'd15) ? `PMLC_ADDR_MAX : win[3:0];
			end else begin
				nxt_cnt = cnt_ff + CW'(1);
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1_ff   <= 12'h000;
			s2_ff   <= 12'h000;
			cnt_ff  <= '0;
			addr_ff <= 4'h0;
			val_ff  <= 1'b0;
		end else begin
			s1_ff   <= strap_mv;
			s2_ff   <= s1_ff;
			cnt_ff  <= nxt_cnt;
			addr_ff <= nxt_addr;
			val_ff  <= nxt_val;
		end
	end

	assign addr       = addr_ff;
	assign addr_valid = val_ff;

	a_addr_frozen: assert property (@(posedge clk) disable iff (rst)
		val_ff |=> (val_ff && $stable(addr_ff)))
		else $error("strap address changed after capture");
	a_addr_window: assert property (@(posedge clk) disable iff (rst)
		$rose(val_ff) |-> (addr_ff == (($past(win) > 32'd15) ? 4'hF : $past(win[3:0]))))
		else $error("strap window decode wrong");
endmodule : pmlc_addr_strap

//--- pmlc_host_model.sv
`timescale 1ns/1ps
module pmlc_host_model import pmlc_pkg::*; (
	// Link outputs
	output logic            link_clk,
	output logic            link_req,
	output logic            link_rd,
	output logic [7:0]      link_cmd,
	output pmlc_word_t      link_wdata,
	// Link answer
	input  wire logic       link_busy,
	input  wire logic       link_rvalid,
	input  wire pmlc_word_t link_rdata
);
	logic run;
	int   n;
	logic done;
	initial begin
		link_clk = 1'b0;
		run = 1'b0;
		link_req = 1'b0;
		link_rd = 1'b1;
		link_cmd = 8'hFF;
		link_wdata = 16'hFFFF;
	end
	// Clock stands low between transfers; a started high phase always finishes
	always begin
		#16;
		if (run || link_clk) link_clk = ~link_clk;
	end
	task automatic ticks(input int cnt);
		run = 1'b1;
		repeat (cnt) @(posedge link_clk);
		run = 1'b0;
	endtask : ticks
	task automatic xfer(input logic rd, input logic [7:0] cmd, input pmlc_word_t wd,
		output pmlc_word_t rdat, output logic ok);
		ok = 1'b0;
		done = 1'b0;
		rdat = 16'h0000;
		run = 1'b1;
		@(posedge link_clk);
		#2;
		link_req = 1'b1;
		link_rd = rd;
		link_cmd = cmd;
		link_wdata = wd;
		@(posedge link_clk);
		#2;
		// Released lines show the inverse so a stale value cannot pass
		link_req = 1'b0;
		link_rd = ~rd;
		link_cmd = ~cmd;
		link_wdata = ~wd;
		for (n = 0; n < 40 && !done; n++) begin
			@(posedge link_clk);
			#1;
			if (link_busy === 1'b0) begin
				done = 1'b1;
				ok = (link_rvalid === rd);
				rdat = link_rdata;
			end
		end
		repeat (2) @(posedge link_clk);
		run = 1'b0;
	endtask : xfer
endmodule : pmlc_host_model

//--- tb.sv
`timescale 1ns/1ps
`include "pmlc_defines.svh"
module tb import pmlc_pkg::*; ();
	logic clk, rst, lclk, lreq, lrd, lbusy, lrv, bias, below, hip, uvd;
	logic [7:0] lcmd;
	pmlc_word_t lwd, lrdat, vin, iin, temp, vlo, ovlo, d;
	logic [11:0] strap;
	logic [3:0] bus_addr;
	logic addr_valid, conv_run, nv_busy, nv_store, wr_ref;
	logic [5:0] flags;
	int n_errors = 0, check_count = 0, cyc = 0, ref_cnt = 0, store_cnt = 0;
	pmlc_top #(.COMMIT_CYC(20), .TICK_CYC(10), .ADDR_CYC(8)) dut_u (.CLK(clk), .RST(rst),
		.LINK_CLK(lclk), .LINK_REQ(lreq), .LINK_RD(lrd), .LINK_CMD(lcmd), .LINK_WDATA(lwd),
		.LINK_BUSY(lbusy), .LINK_RVALID(lrv), .LINK_RDATA(lrdat), .BIAS_PRESENT(bias),
		.HI_BELOW_UVLO(below), .HI_PRESENT(hip), .UV_DELAY_DONE(uvd), .VIN_MEAS(vin),
		.IIN_MEAS(iin), .TEMP_MEAS(temp), .VLO_MEAS(vlo), .ADDR_STRAP_MV(strap),
		.BUS_ADDR(bus_addr), .ADDR_VALID(addr_valid), .OVLO_LEVEL(ovlo), .CONV_RUN(conv_run),
		.NV_BUSY(nv_busy), .NV_STORE(nv_store), .WR_REFUSED(wr_ref), .LIMIT_FLAGS(flags));
	pmlc_host_model host_u (.link_clk(lclk), .link_req(lreq), .link_rd(lrd),
		.link_cmd(lcmd), .link_wdata(lwd), .link_busy(lbusy), .link_rvalid(lrv),
		.link_rdata(lrdat));
	// ************************************************************
	// Clock, watchers, checks
	// ************************************************************
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (wr_ref === 1'b1) ref_cnt++;
		if (nv_store === 1'b1) store_cnt++;
		if (cyc == 20000) begin
			n_errors++;
			end_sim();
		end
	end
	task automatic end_sim();
		if (n_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : end_sim
	task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic step(input int k);
		repeat (k) @(posedge clk);
		#2;
	endtask : step
	task automatic rd(input logic [7:0] c, output pmlc_word_t v);
		logic ok;
		host_u.xfer(1'b1, c, 16'h0000, v, ok);
		chk("read answer", {15'h0000, ok}, 16'h0001);
		// Realign to the core clock so later pin changes follow its edge
		step(1);
	endtask : rd
	task automatic wr(input logic [7:0] c, input pmlc_word_t v);
		logic ok;
		pmlc_word_t dummy;
		host_u.xfer(1'b0, c, v, dummy, ok);
		chk("write answer", {15'h0000, ok}, 16'h0001);
		step(1);
	endtask : wr
	task automatic wait_commit();
		int k;
		for (k = 0; k < 100 && nv_busy !== 1'b0; k++) step(1);
	endtask : wait_commit
	task automatic do_reset();
		rst = 1'b1;
		fork
			host_u.ticks(6);
			step(12);
		join
		rst = 1'b0;
		step(20);
	endtask : do_reset
	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic t_defaults();
		logic [7:0] cm [8] = '{`PMLC_CMD_OT_FAULT, `PMLC_CMD_OT_WARN, `PMLC_CMD_OV_FAULT,
			`PMLC_CMD_OV_WARN, `PMLC_CMD_OC_FAULT, `PMLC_CMD_OC_WARN, `PMLC_CMD_TON, `PMLC_CMD_UV_OVR};
		pmlc_word_t ex [8] = '{`PMLC_DEF_OT, `PMLC_DEF_OT, `PMLC_DEF_OV, `PMLC_DEF_OV,
			`PMLC_DEF_OC, `PMLC_DEF_OC, `PMLC_DEF_TON, `PMLC_DEF_UV};
		for (int i = 0; i < 8; i++) begin
			rd(cm[i], d);
			chk("default limit", d, ex[i]);
		end
		rd(8'h33, d);
		chk("unmapped read", d, 16'h0000);
		rd(`PMLC_CMD_READ_TEMP, d);
		chk("disabled temp", d, 16'hFEEF);
		rd(`PMLC_CMD_READ_VLO, d);
		chk("disabled vlo", d, 16'hF448);
		chk("flags default", {10'h000, flags}, 16'h003F);
	endtask : t_defaults
	task automatic t_window();
		int s0;
		s0 = store_cnt;
		wr(`PMLC_CMD_OV_FAULT, 16'h2710);
		chk("commit busy", {15'h0000, nv_busy}, 16'h0001);
		wait_commit();
		step(2);
		chk("commit pulses", 16'(store_cnt - s0), 16'h0001);
		rd(`PMLC_CMD_OV_FAULT, d);
		chk("ov limit", d, 16'h2710);
		// 10000 less 3 percent is 9700
		chk("ovlo level", ovlo, 16'h25E4);
		chk("flags after ov", {10'h000, flags}, 16'h003E);
		wr(`PMLC_CMD_UV_OVR, 16'h1234);
		wait_commit();
		rd(`PMLC_CMD_UV_OVR, d);
		chk("uv override", d, 16'h0FA0);
		wr(`PMLC_CMD_TON, 16'h00C8);
		wait_commit();
		rd(`PMLC_CMD_TON, d);
		chk("ton clamp", d, 16'h0064);
		wr(`PMLC_CMD_TON, 16'h0002);
		wait_commit();
	endtask : t_window
	task automatic t_refuse();
		int r0;
		r0 = ref_cnt;
		below = 1'b0;
		step(4);
		wr(`PMLC_CMD_OC_FAULT, 16'h0001);
		below = 1'b1;
		bias = 1'b0;
		step(4);
		wr(`PMLC_CMD_OC_WARN, 16'h0001);
		wr(`PMLC_CMD_OPERATION, 16'h0080);
		bias = 1'b1;
		step(4);
		chk("refusals", 16'(ref_cnt - r0), 16'h0003);
		rd(`PMLC_CMD_OC_FAULT, d);
		chk("oc fault kept", d, `PMLC_DEF_OC);
		rd(`PMLC_CMD_OC_WARN, d);
		chk("oc warn kept", d, `PMLC_DEF_OC);
		rd(`PMLC_CMD_OPERATION, d);
		chk("operation kept", d, 16'h0000);
	endtask : t_refuse
	task automatic t_start();
		int k, r0;
		uvd = 1'b1;
		wr(`PMLC_CMD_OPERATION, 16'h0080);
		below = 1'b0;
		for (k = 0; k < 100 && conv_run !== 1'b1; k++) step(1);
		// Two ticks of ten cycles plus synchroniser latency
		chk("startup_extra_delay", {15'h0000, k >= 20 && k <= 30}, 16'h0001);
		rd(`PMLC_CMD_READ_TEMP, d);
		chk("enabled temp", d, 16'h0080);
		rd(`PMLC_CMD_READ_VLO, d);
		chk("enabled vlo", d, 16'h0155);
		r0 = ref_cnt;
		wr(`PMLC_CMD_OT_FAULT, 16'h0005);
		step(4);
		chk("enabled refusal", 16'(ref_cnt - r0), 16'h0001);
		rd(`PMLC_CMD_OT_FAULT, d);
		chk("ot kept", d, `PMLC_DEF_OT);
		below = 1'b1;
		step(6);
		chk("run drops", {15'h0000, conv_run}, 16'h0000);
		bias = 1'b0;
		hip = 1'b0;
		step(6);
		rd(`PMLC_CMD_READ_TEMP, d);
		chk("lost telemetry", d, 16'h0000);
		bias = 1'b1;
		hip = 1'b1;
	endtask : t_start
	task automatic t_strap();
		chk("addr valid", {15'h0000, addr_valid}, 16'h0001);
		// 1650 mV sits in window 8
		chk("addr mid", {12'h000, bus_addr}, 16'h0008);
		strap = 12'hCE4;
		step(20);
		chk("addr held", {12'h000, bus_addr}, 16'h0008);
		do_reset();
		chk("addr top clamp", {12'h000, bus_addr}, 16'h000F);
	endtask : t_strap
	initial begin
		rst = 1'b1;
		bias = 1'b1;
		below = 1'b1;
		hip = 1'b1;
		uvd = 1'b0;
		vin = 16'h2000;
		iin = 16'h1200;
		temp = 16'h0080;
		vlo = 16'h0155;
		strap = 12'h672;
		do_reset();
		t_defaults();
		t_window();
		t_refuse();
		t_start();
		t_strap();
		end_sim();
	end
endmodule : tb
